/* File: include/wpg_pkg.sv */
// Purpose: Constants shared by the dual waveform generator.
// Assumes: 100 MHz core clock, 16-bit register port at word offsets.
// Notes: Tick of 266.667 ns is made as three ticks per 800 ns.
`default_nettype none
package wpg_pkg;
   ////////////////////////////////////////////////////////////////////////////
   // Register map
   localparam int ADDR_W = 10;
   localparam int DATA_W = 16;
   localparam logic [9:0] OFF_WAVE0_CONTROL = 10'h3d8;
   localparam logic [9:0] OFF_WAVE0_HIGH_TIME = 10'h3d9;
   localparam logic [9:0] OFF_WAVE0_LOW_TIME = 10'h3da;
   localparam logic [9:0] OFF_WAVE1_CONTROL = 10'h3db;
   localparam logic [9:0] OFF_WAVE1_HIGH_TIME = 10'h3dc;
   localparam logic [9:0] OFF_WAVE1_LOW_TIME = 10'h3dd;
   localparam logic [9:0] CH_STRIDE = 10'h003;
   ////////////////////////////////////////////////////////////////////////////
   // Fields
   localparam int PIN_LSB = 0;
   localparam int PIN_W = 5;
   localparam int ENABLE_BIT = 5;
   localparam int CMD_LSB = 6;
   localparam int CMD_W = 3;
   localparam int TIME_W = 12;
   localparam logic [15:0] CTRL_A_MASK = 16'h01ff;
   localparam logic [15:0] CTRL_B_MASK = 16'h01df;
   localparam logic [15:0] TIME_MASK = 16'h0fff;
   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [11:0] TIME_RESET = 12'h001;
   ////////////////////////////////////////////////////////////////////////////
   // Commands
   localparam logic [2:0] CMD_IDLE = 3'h0;
   localparam logic [2:0] CMD_LOW = 3'h4;
   localparam logic [2:0] CMD_SHOT = 3'h5;
   localparam logic [2:0] CMD_RUN = 3'h6;
   localparam logic [2:0] CMD_LOW_ALT = 3'h7;
   ////////////////////////////////////////////////////////////////////////////
   // Timing: three ticks per 800 ns window
   localparam int CLK_PERIOD_NS = 10;
   localparam int WINDOW_NS = 800;
   localparam int TICKS_PER_WINDOW = 3;
   localparam int WINDOW_CYC = WINDOW_NS / CLK_PERIOD_NS;
   localparam logic [6:0] TICK_STEP = 7'(TICKS_PER_WINDOW);
   localparam logic [6:0] TICK_MOD = 7'(WINDOW_CYC);
   ////////////////////////////////////////////////////////////////////////////
   typedef enum logic [3:0] {
      ST_HOLD = 4'b0001,
      ST_SHOT = 4'b0010,
      ST_HIGH = 4'b0100,
      ST_LOW  = 4'b1000
   } wpg_state_t;
endpackage : wpg_pkg
`default_nettype wire

/* File: rtl/wpg_waveform_pair.sv */
// Purpose: Two waveform channels steering any of 32 dedicated I/O lines.
// Assumes: Register port inputs synchronous to I_CORE_CLK.
// Notes: Read data appears one cycle after I_REG_RD.
// Notes: Each control write restarts its channel and that channel's tick.
`default_nettype none
module wpg_waveform_pair #(
   parameter int NUM_LINES = 32
) (
   input wire logic I_CORE_CLK,
   input wire logic I_RESET_N,
   input wire logic I_REG_WR,
   input wire logic I_REG_RD,
   input wire logic [wpg_pkg::ADDR_W-1:0] I_REG_ADDR,
   input wire logic [wpg_pkg::DATA_W-1:0] I_REG_WDATA,
   output logic [wpg_pkg::DATA_W-1:0] O_REG_RDATA,
   output logic [NUM_LINES-1:0] O_IO_LEVEL,
   output logic [NUM_LINES-1:0] O_IO_DRIVE_EN
);
   import wpg_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Channels
   logic [15:0] ctrl_ff [2];
   logic [11:0] high_ff [2];
   logic [11:0] low_ff [2];
   logic [1:0] level;
   logic [1:0] drive;

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_ch
         localparam logic [9:0] OFF_C = OFF_WAVE0_CONTROL + 10'(ch * 3);
         localparam logic [9:0] OFF_H = OFF_WAVE0_HIGH_TIME + 10'(ch * 3);
         localparam logic [9:0] OFF_L = OFF_WAVE0_LOW_TIME + 10'(ch * 3);
         localparam logic [15:0] C_MASK = (ch == 0) ? CTRL_A_MASK : CTRL_B_MASK;

         logic wr_ctrl;
         logic [2:0] wr_cmd;

         logic [6:0] tick_acc_ff;
         logic [6:0] nxt_tick_acc;
         logic tick;
         wpg_state_t state_ff;
         logic out_ff;
         logic active_ff;
         logic [11:0] cnt_ff;
         logic phase_end;

         assign wr_ctrl = I_REG_WR && (I_REG_ADDR == OFF_C);
         assign wr_cmd = I_REG_WDATA[CMD_LSB +: CMD_W];
         // Zero period behaves as one tick rather than wrapping to 4096
         assign phase_end = tick && (cnt_ff <= 12'h001);

         // Tick divider, 3 ticks every 80 clocks; restarted by each control
         // write so a shared tick can never cut the first phase short
         always_comb begin
            nxt_tick_acc = tick_acc_ff + TICK_STEP;
            tick = 1'b0;
            if (nxt_tick_acc >= TICK_MOD) begin
               nxt_tick_acc = nxt_tick_acc - TICK_MOD;
               tick = 1'b1;
            end
         end

         always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
            if (!I_RESET_N) begin
               tick_acc_ff <= 7'h00;
            end else if (wr_ctrl) begin
               tick_acc_ff <= 7'h00;
            end else begin
               tick_acc_ff <= nxt_tick_acc;
            end
         end

         // Reserved bits are not stored and read back as zero
         // Channel b mask also drops bit 5, it has no enable
         always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
            if (!I_RESET_N) begin
               ctrl_ff[ch] <= CTRL_RESET;
            end else if (wr_ctrl) begin
               ctrl_ff[ch] <= I_REG_WDATA & C_MASK;
            end
         end

         always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
            if (!I_RESET_N) begin
               high_ff[ch] <= TIME_RESET;
            end else if (I_REG_WR && (I_REG_ADDR == OFF_H)) begin
               high_ff[ch] <= I_REG_WDATA[TIME_W-1:0];
            end
         end

         always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
            if (!I_RESET_N) begin
               low_ff[ch] <= TIME_RESET;
            end else if (I_REG_WR && (I_REG_ADDR == OFF_L)) begin
               low_ff[ch] <= I_REG_WDATA[TIME_W-1:0];
            end
         end

         // Each control write starts the written command afresh
         always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
            if (!I_RESET_N) begin
               state_ff <= ST_HOLD;
            end else if (wr_ctrl) begin
               unique case (wr_cmd)
                  CMD_IDLE: begin
                     state_ff <= ST_HOLD;
                  end
                  CMD_LOW, CMD_LOW_ALT: begin
                     state_ff <= ST_HOLD;
                  end
                  CMD_SHOT: begin
                     state_ff <= ST_SHOT;
                  end
                  CMD_RUN: begin
                     state_ff <= ST_HIGH;
                  end
                  default: begin
                     // Undefined codes freeze the level like idle
                     state_ff <= ST_HOLD;
                  end
               endcase
            // Phase ends step the state; holding ignores them
            end else if (phase_end) begin
               unique case (state_ff)
                  ST_HOLD: begin
                     state_ff <= ST_HOLD;
                  end
                  ST_SHOT: begin
                     state_ff <= ST_HOLD;
                  end
                  ST_HIGH: begin
                     state_ff <= ST_LOW;
                  end
                  ST_LOW: begin
                     state_ff <= ST_HIGH;
                  end
               endcase
            end
         end

         // Level follows command writes, then flips at each phase end except while holding
         always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
            if (!I_RESET_N) begin
               out_ff <= 1'b0;
            end else if (wr_ctrl) begin
               unique case (wr_cmd)
                  CMD_IDLE: begin
                     out_ff <= out_ff;
                  end
                  CMD_LOW, CMD_LOW_ALT: begin
                     out_ff <= 1'b0;
                  end
                  CMD_SHOT: begin
                     out_ff <= ~out_ff;
                  end
                  CMD_RUN: begin
                     out_ff <= 1'b1;
                  end
                  default: begin
                     // Undefined codes leave the pin alone
                     out_ff <= out_ff;
                  end
               endcase
            end else if (phase_end && (state_ff != ST_HOLD)) begin
               // Shot returns to prior level, free run alternates
               out_ff <= ~out_ff;
            end
         end

         // Periods are sampled only at phase start, so rewrites never cut a phase
         always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
            if (!I_RESET_N) begin
               cnt_ff <= TIME_RESET;
            end else if (wr_ctrl) begin
               unique case (wr_cmd)
                  CMD_SHOT: begin
                     cnt_ff <= out_ff ? low_ff[ch] : high_ff[ch];
                  end
                  CMD_RUN: begin
                     cnt_ff <= high_ff[ch];
                  end
                  CMD_IDLE: begin
                     cnt_ff <= cnt_ff;
                  end
                  default: begin
                     cnt_ff <= cnt_ff;
                  end
               endcase
            end else if (tick) begin
               unique case (state_ff)
                  ST_HOLD: begin
                     cnt_ff <= cnt_ff;
                  end
                  ST_SHOT: begin
                     cnt_ff <= phase_end ? cnt_ff : cnt_ff - 12'h001;
                  end
                  ST_HIGH: begin
                     cnt_ff <= phase_end ? low_ff[ch] : cnt_ff - 12'h001;
                  end
                  ST_LOW: begin
                     cnt_ff <= phase_end ? high_ff[ch] : cnt_ff - 12'h001;
                  end
               endcase
            end
         end

         // Channel b has no enable, so it claims its pin at first drive command
         always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
            if (!I_RESET_N) begin
               active_ff <= 1'b0;
            end else if (wr_ctrl && wr_cmd[2]) begin
               active_ff <= 1'b1;
            end
         end

         assign level[ch] = out_ff;
         if (ch == 0) begin : g_en
            assign drive[ch] = ctrl_ff[ch][ENABLE_BIT];
         end else begin : g_noen
            assign drive[ch] = active_ff;
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Pin steering; channel a wins if both pick the same line
   wire logic [NUM_LINES-1:0] nxt_io_level;
   wire logic [NUM_LINES-1:0] nxt_io_drive;

   genvar ln;
   generate
      for (ln = 0; ln < NUM_LINES; ln++) begin : g_line
         logic pick_a;
         logic pick_b;

         assign pick_a = drive[0] && (ctrl_ff[0][PIN_LSB +: PIN_W] == PIN_W'(ln));
         assign pick_b = drive[1] && (ctrl_ff[1][PIN_LSB +: PIN_W] == PIN_W'(ln));
         // Undriven lines report low so the far side sees only its pull
         assign nxt_io_drive[ln] = pick_a || pick_b;
         assign nxt_io_level[ln] = pick_a ? level[0] : (pick_b && level[1]);
      end
   endgenerate

   // Enable and level registered apart, both settle in the same cycle
   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_IO_DRIVE_EN <= {NUM_LINES{1'b0}};
      end else begin
         O_IO_DRIVE_EN <= nxt_io_drive;
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_IO_LEVEL <= {NUM_LINES{1'b0}};
      end else begin
         O_IO_LEVEL <= nxt_io_level;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register read; unmapped offsets return zero
   // so a probing read can never disturb a channel
   logic [15:0] nxt_rdata;

   always_comb begin
      unique case (I_REG_ADDR)
         OFF_WAVE0_CONTROL: nxt_rdata = ctrl_ff[0];
         OFF_WAVE0_HIGH_TIME: nxt_rdata = {4'h0, high_ff[0]};
         OFF_WAVE0_LOW_TIME: nxt_rdata = {4'h0, low_ff[0]};
         OFF_WAVE1_CONTROL: nxt_rdata = ctrl_ff[1];
         OFF_WAVE1_HIGH_TIME: nxt_rdata = {4'h0, high_ff[1]};
         OFF_WAVE1_LOW_TIME: nxt_rdata = {4'h0, low_ff[1]};
         default: nxt_rdata = 16'h0000;
      endcase
   end

   // Read data holds between strobes
   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_REG_RDATA <= 16'h0000;
      end else if (I_REG_RD) begin
         O_REG_RDATA <= nxt_rdata;
      end
   end
endmodule : wpg_waveform_pair
`default_nettype wire

/* File: tb/wpg_pair_sva.sv */
// Purpose: Port checks of the waveform pair.
// Assumes: Channel a pin follows its last enabled control write.
// Notes: Pin checks rely on channel a winning a shared line.
`default_nettype none
module wpg_pair_sva (
   input wire logic I_CORE_CLK,
   input wire logic I_RESET_N,
   input wire logic I_REG_WR,
   input wire logic I_REG_RD,
   input wire logic [wpg_pkg::ADDR_W-1:0] I_REG_ADDR,
   input wire logic [wpg_pkg::DATA_W-1:0] I_REG_WDATA,
   input wire logic [wpg_pkg::DATA_W-1:0] O_REG_RDATA,
   input wire logic [31:0] O_IO_LEVEL,
   input wire logic [31:0] O_IO_DRIVE_EN
);
   import wpg_pkg::*;
   logic [4:0] pin_ff;
   wire logic wa = I_REG_WR && I_REG_ADDR == OFF_WAVE0_CONTROL && I_REG_WDATA[ENABLE_BIT];
   wire logic [2:0] cmd = I_REG_WDATA[8:6];
   wire logic unmapped = I_REG_ADDR < OFF_WAVE0_CONTROL || I_REG_ADDR > OFF_WAVE1_LOW_TIME;
   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) pin_ff <= 5'h00;
      else if (wa) pin_ff <= I_REG_WDATA[4:0];
   end
   default clocking @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RESET_N);
   ////////////////////////////////////////////////////////////////////////////
   a_rdata_holds:
      assert property (!I_REG_RD |=> $stable(O_REG_RDATA)) else $error("read data moved");
   a_unmapped_zero:
      assert property (I_REG_RD && unmapped |=> O_REG_RDATA == 16'h0000) else $error("unmapped");
   a_ctrl_reserved:
      assert property (I_REG_RD && I_REG_ADDR == OFF_WAVE0_CONTROL |=> O_REG_RDATA[15:9] == 7'h00)
         else $error("control reserved bits");
   a_time_reserved:
      assert property (I_REG_RD && I_REG_ADDR == OFF_WAVE0_HIGH_TIME |=> O_REG_RDATA[15:12] == 4'h0)
         else $error("time reserved bits");
   a_chb_no_enable:
      assert property (I_REG_RD && I_REG_ADDR == OFF_WAVE1_CONTROL |=> O_REG_RDATA[5] == 1'b0)
         else $error("channel b enable bit stored");
   a_low_steady:
      assert property (wa && (cmd == CMD_LOW || cmd == CMD_LOW_ALT) ##1 !I_REG_WR
         |=> O_IO_DRIVE_EN[pin_ff] && !O_IO_LEVEL[pin_ff]) else $error("low command");
   a_run_starts_high:
      assert property (wa && cmd == CMD_RUN ##1 !I_REG_WR |=> O_IO_LEVEL[pin_ff])
         else $error("free run start");
   a_shot_flips:
      assert property (wa && cmd == CMD_SHOT ##1 !I_REG_WR && O_IO_DRIVE_EN[pin_ff]
         |=> O_IO_LEVEL[pin_ff] != $past(O_IO_LEVEL[pin_ff])) else $error("one-shot polarity");
   a_idle_holds:
      assert property (wa && cmd == CMD_IDLE ##1 (!I_REG_WR)[*8]
         |-> O_IO_LEVEL[pin_ff] == $past(O_IO_LEVEL[pin_ff], 6)) else $error("idle moved");
endmodule : wpg_pair_sva
bind wpg_waveform_pair wpg_pair_sva u_pair_sva (.I_CORE_CLK(I_CORE_CLK), .I_RESET_N(I_RESET_N),
   .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD), .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA),
   .O_REG_RDATA(O_REG_RDATA), .O_IO_LEVEL(O_IO_LEVEL), .O_IO_DRIVE_EN(O_IO_DRIVE_EN));
`default_nettype wire

/* File: tb/wpg_line_probe.sv */
// Purpose: Far-side peripheral watching the I/O lines.
// Assumes: Weak pull-up on every undriven line.
// Notes: Measures run lengths of one selected line, in clocks.
`default_nettype none
module wpg_line_probe (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic [31:0] i_level,
   input wire logic [31:0] i_drive_en,
   input wire logic [4:0] i_sel,
   output logic [31:0] o_wire,
   output logic [15:0] o_high_len,
   output logic [15:0] o_low_len
);
   logic [15:0] run_ff;
   // Released lines float high, never keep their last value
   assign o_wire = i_level | ~i_drive_en;
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         run_ff <= 16'h0001;
         o_high_len <= 16'h0000;
         o_low_len <= 16'h0000;
      end else if (o_wire[i_sel] == $past(o_wire[i_sel])) begin
         run_ff <= run_ff + 16'h0001;
      end else begin
         run_ff <= 16'h0001;
         if (o_wire[i_sel]) o_low_len <= run_ff;
         else o_high_len <= run_ff;
      end
   end
endmodule : wpg_line_probe
`default_nettype wire

/* File: tb/wpg_waveform_pair_tb.sv */
// Purpose: Register and pin tests of the waveform pair.
// Assumes: Strobe port with one-cycle read latency.
// Notes: Phase lengths are checked as windows, the tick is fractional.
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module wpg_waveform_pair_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import wpg_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [9:0] addr = 10'h000;
   logic [15:0] wdata = 16'h0000, rdata, hl, ll, d;
   logic [31:0] lvl, den, wl;
   logic [4:0] sel = 5'h03;
   int bad_count = 0, num_checks = 0;
   wpg_waveform_pair dut (.I_CORE_CLK(clk), .I_RESET_N(rst_n), .I_REG_WR(wr), .I_REG_RD(rd),
      .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .O_IO_LEVEL(lvl),
      .O_IO_DRIVE_EN(den));
   wpg_line_probe u_probe (.i_clk(clk), .i_reset_n(rst_n), .i_level(lvl), .i_drive_en(den),
      .i_sel(sel), .o_wire(wl), .o_high_len(hl), .o_low_len(ll));
   ////////////////////////////////////////////////////////////////////////////
   task automatic wr_reg(input logic [9:0] a, input logic [15:0] v);
      @(posedge clk);
      #1 wr = 1'b1;
      addr = a;
      wdata = v;
      @(posedge clk);
      #1 wr = 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [9:0] a, output logic [15:0] v);
      @(posedge clk);
      #1 rd = 1'b1;
      addr = a;
      @(posedge clk);
      #1 rd = 1'b0;
      v = rdata;
   endtask : rd_reg
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : wt
   // Phase of n ticks: ticks 26 or 27 clocks apart, small slack for the pin stage
   task automatic runs(input int h, input int l);
      `CHK("high run", 1'b1, hl >= 26 * (h - 1) && hl <= 27 * h + 2)
      `CHK("low run", 1'b1, ll >= 26 * (l - 1) && ll <= 27 * l + 2)
   endtask : runs
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : stop_test
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      stop_test();
   end
   initial begin
      repeat (10) @(posedge clk);
      #1 rst_n = 1'b1;
      for (int i = 0; i < 6; i++) begin
         rd_reg(OFF_WAVE0_CONTROL + 10'(i), d);
         `CHK("reset value", (i % 3 == 0) ? CTRL_RESET : {4'h0, TIME_RESET}, d)
         wr_reg(OFF_WAVE0_CONTROL + 10'(i), 16'hffff);
         rd_reg(OFF_WAVE0_CONTROL + 10'(i), d);
         `CHK("stored bits", (i == 0) ? CTRL_A_MASK : (i == 3) ? CTRL_B_MASK : TIME_MASK, d)
      end
      wr_reg(10'h3de, 16'h1234);
      rd_reg(10'h3de, d);
      `CHK("unmapped", 16'h0000, d)
      `CHK("cmd 111 pin 31", 2'b10, {den[31], lvl[31]})
      wr_reg(OFF_WAVE0_CONTROL, 16'h0127);
      wt(2);
      `CHK("cmd 100 pin 7", 2'b10, {den[7], lvl[7]})
      $display("test registers done");
      wr_reg(OFF_WAVE0_HIGH_TIME, 16'h0003);
      wr_reg(OFF_WAVE0_LOW_TIME, 16'h0001);
      wr_reg(OFF_WAVE0_CONTROL, 16'h01a3);
      wt(2);
      `CHK("run start", 2'b11, {den[3], lvl[3]})
      wt(400);
      runs(3, 1);
      wr_reg(OFF_WAVE0_CONTROL, 16'h01a3);
      wt(5);
      wr_reg(OFF_WAVE0_CONTROL, 16'h0023);
      wt(200);
      `CHK("idle hold", 1'b1, wl[3])
      wr_reg(OFF_WAVE0_LOW_TIME, 16'h0004);
      wr_reg(OFF_WAVE0_CONTROL, 16'h0163);
      wt(2);
      `CHK("low pulse", 1'b0, lvl[3])
      wt(300);
      `CHK("low pulse run", 1'b1, ll >= 26 * 3 && ll <= 27 * 4 + 2)
      `CHK("held high run", 1'b1, hl >= 16'd200)
      `CHK("after low pulse", 1'b1, lvl[3])
      wr_reg(OFF_WAVE0_CONTROL, 16'h0123);
      wr_reg(OFF_WAVE0_HIGH_TIME, 16'h0001);
      wr_reg(OFF_WAVE0_CONTROL, 16'h0163);
      wt(2);
      `CHK("high pulse", 1'b1, lvl[3])
      wt(100);
      `CHK("high pulse run", 1'b1, hl >= 26 && hl <= 27 + 2)
      `CHK("forced low gap", 1'b1, ll >= 3 && ll <= 6)
      `CHK("after high pulse", 1'b0, lvl[3])
      $display("test channel a done");
      wr_reg(OFF_WAVE0_CONTROL, 16'h0189);
      wt(100);
      `CHK("disabled pin 9", 1'b0, den[9])
      sel = 5'h14;
      wr_reg(OFF_WAVE1_HIGH_TIME, 16'h0002);
      wr_reg(OFF_WAVE1_LOW_TIME, 16'h0002);
      wr_reg(OFF_WAVE1_CONTROL, 16'h0194);
      wt(2);
      `CHK("channel b start", 2'b11, {den[20], lvl[20]})
      wt(400);
      runs(2, 2);
      $display("test channel b done");
      stop_test();
   end
endmodule : wpg_waveform_pair_tb
`default_nettype wire
